// [rtl/qdc_pkg.sv]
// constants shared by the quad converter update-control logic
// assumes a system clock of 100 MHz and a host-driven serial clock
package qdc_pkg;
   localparam int NUM_CH = 4;
   localparam int DATA_BITS = 16;
   localparam int WORD_BITS = 24;
   localparam int CNT_BITS = 5;
   // frame layout: channel address in [17:16], code in [15:0]
   localparam int CH_LSB = 16;
   localparam int CH_BITS = 2;
   localparam int DATA_LSB = 0;
   localparam logic [CNT_BITS-1:0] WORD_COUNT = 5'h18;
   localparam logic [CNT_BITS-1:0] COUNT_MAX = 5'h1F;
   localparam logic [CNT_BITS-1:0] COUNT_RESET = 5'h00;
   localparam logic [WORD_BITS-1:0] SHIFT_RESET = 24'h000000;
   localparam logic [DATA_BITS-1:0] RESET_CODE = 16'h0000;
   localparam logic [DATA_BITS-1:0] ZERO_SCALE = 16'h0000;
   localparam logic [DATA_BITS-1:0] MID_SCALE = 16'h8000;
   localparam logic [DATA_BITS-1:0] SIGN_FLIP = 16'h8000;
   localparam int SYNC_STAGES = 2;
   localparam int PIN_SYNC_W = 6;
endpackage : qdc_pkg

// [rtl/qdc_sync.sv]
// two-stage synchroniser for a bundle of independent level inputs
// assumes each bit is a slow level; no bus coherence is implied
module qdc_sync
   import qdc_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // levels
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] q_reg;

   // first stage is read only by the second stage
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_reg <= INIT;
         q_reg <= INIT;
      end else begin
         meta_reg <= d_i;
         q_reg <= meta_reg;
      end
   end

   assign q_o = q_reg;
endmodule : qdc_sync

// [rtl/qdc_update_ctrl.sv]
// update and clear control of a quad serial-input converter
// assumes sclk_i comes from the host and may stop between frames;
// all pins other than the serial pair are synchronised to clk_i
//
// Functional notes
// - With load held low, the addressed output register updates when a frame ends.
// - With load high during a write, only the input register takes the word.
// - A falling load edge copies all four input registers to the outputs at once.
// - While clear is low all channel registers are forced to zero or midscale.
// - The shift register contents leave on the serial data output for chaining.
// - The serial output changes on rising serial clock and is read on the falling.
// - Bits shift in on falling serial clock while frame select is low; the word latches when it rises.
// - Bipolar codes are offset binary with coding select high, twos complement low.
// - A frame carries exactly twenty-four bits; longer or shorter ones are dropped, save a frame with no sclk edge, which repeats the last word.
// - Power-on reset loads every channel register with zero.
module qdc_update_ctrl
   import qdc_pkg::*;
(
   // system clock and power-on reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // serial link
   input wire logic sclk_i,
   input wire logic frame_sel_n_i,
   input wire logic serial_data_in_i,
   output logic serial_data_out_o,
   // control pins
   input wire logic load_outputs_n_i,
   input wire logic clear_all_n_i,
   input wire logic clear_midscale_i,
   input wire logic coding_select_i,
   input wire logic range_bipolar_i,
   // converter core codes, channel 0 in the low bits
   output logic [NUM_CH*DATA_BITS-1:0] core_code_o
);
   // ***************************************************
   // serial clock domain
   // ***************************************************
   logic [WORD_BITS-1:0] shift_reg;
   logic [CNT_BITS-1:0] bit_cnt_reg;
   logic fresh_reg;
   logic sdo_reg;

   // shifting is gated by the frame, so the word is still once it ends
   always_ff @(negedge sclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shift_reg <= SHIFT_RESET;
      end else if (!frame_sel_n_i) begin
         shift_reg <= {shift_reg[WORD_BITS-2:0], serial_data_in_i};
      end
   end

   // a frame rise only arms a restart; clearing the count there would
   // wipe the length before the clk side has judged the word
   // limitation: a frame with no sclk edge at all repeats the last word
   always_ff @(negedge sclk_i or posedge frame_sel_n_i
               or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fresh_reg <= 1'b1;
      end else if (frame_sel_n_i) begin
         fresh_reg <= 1'b1;
      end else begin
         fresh_reg <= 1'b0;
      end
   end

   // count holds after the frame, so the length is still while read
   always_ff @(negedge sclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bit_cnt_reg <= COUNT_RESET;
      end else if (!frame_sel_n_i) begin
         if (fresh_reg) begin
            bit_cnt_reg <= COUNT_RESET + 5'h01;
         end else if (bit_cnt_reg != COUNT_MAX) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
         end
      end
   end

   always_ff @(posedge sclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sdo_reg <= 1'b0;
      end else begin
         sdo_reg <= shift_reg[WORD_BITS-1];
      end
   end

   assign serial_data_out_o = sdo_reg;

   // ***************************************************
   // pin synchronisers
   // ***************************************************
   logic [PIN_SYNC_W-1:0] pins_s;
   logic frame_s;
   logic load_s;
   logic clear_s;
   logic mid_s;
   logic coding_s;
   logic bipolar_s;

   qdc_sync #(
      .WIDTH(PIN_SYNC_W),
      .INIT(6'h07)
   ) u_pin_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .d_i({range_bipolar_i, coding_select_i, clear_midscale_i,
            clear_all_n_i, load_outputs_n_i, frame_sel_n_i}),
      .q_o(pins_s)
   );

   assign frame_s = pins_s[0];
   assign load_s = pins_s[1];
   assign clear_s = ~pins_s[2];
   assign mid_s = pins_s[3];
   assign coding_s = pins_s[4];
   assign bipolar_s = pins_s[5];

   // ***************************************************
   // frame and load edge detection
   // ***************************************************
   logic frame_d_reg;
   logic load_d_reg;
   logic frame_end;
   logic load_fall;
   logic word_ok;
   logic [CH_BITS-1:0] word_ch;
   logic [DATA_BITS-1:0] word_data;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         frame_d_reg <= 1'b1;
         load_d_reg <= 1'b1;
      end else begin
         frame_d_reg <= frame_s;
         load_d_reg <= load_s;
      end
   end

   assign frame_end = frame_s & ~frame_d_reg;
   assign load_fall = ~load_s & load_d_reg;
   // quasi-static capture: sclk-side word cannot move while the frame is idle
   assign word_ok = (bit_cnt_reg == WORD_COUNT);
   assign word_ch = shift_reg[CH_LSB +: CH_BITS];
   assign word_data = shift_reg[DATA_LSB +: DATA_BITS];

   // ***************************************************
   // channel registers
   // ***************************************************
   // involution between register code and core code (offset binary)
   function automatic logic [DATA_BITS-1:0] to_core(
      input logic [DATA_BITS-1:0] code,
      input logic bipolar,
      input logic offset_bin
   );
      to_core = (bipolar && !offset_bin) ? (code ^ SIGN_FLIP) : code;
   endfunction : to_core

   logic [DATA_BITS-1:0] in_reg [NUM_CH];
   logic [DATA_BITS-1:0] out_reg [NUM_CH];
   logic [DATA_BITS-1:0] core_reg [NUM_CH];
   logic [DATA_BITS-1:0] clear_code;

   assign clear_code = to_core(mid_s ? MID_SCALE : ZERO_SCALE,
                               bipolar_s, coding_s);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < NUM_CH; i++) begin
            in_reg[i] <= RESET_CODE;
         end
      end else if (clear_s) begin
         for (int i = 0; i < NUM_CH; i++) begin
            in_reg[i] <= clear_code;
         end
      end else if (frame_end && word_ok) begin
         in_reg[word_ch] <= word_data;
      end
   end

   // clear has priority over both frame and load updates
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < NUM_CH; i++) begin
            out_reg[i] <= RESET_CODE;
         end
      end else if (clear_s) begin
         for (int i = 0; i < NUM_CH; i++) begin
            out_reg[i] <= clear_code;
         end
      end else if (load_fall) begin
         for (int i = 0; i < NUM_CH; i++) begin
            out_reg[i] <= in_reg[i];
         end
      end else if (frame_end && word_ok && !load_s) begin
         out_reg[word_ch] <= word_data;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < NUM_CH; i++) begin
            core_reg[i] <= RESET_CODE;
         end
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            core_reg[i] <= to_core(out_reg[i], bipolar_s, coding_s);
         end
      end
   end

   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         core_code_o[i*DATA_BITS +: DATA_BITS] = core_reg[i];
      end
   end

   // ***************************************************
   // assertions
   // ***************************************************
   sequence s_good_frame;
      frame_end && word_ok && !clear_s;
   endsequence

   sequence s_bad_frame;
      frame_end && !word_ok;
   endsequence

   a_immediate_update: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      s_good_frame and (!load_s && !load_fall)
      |=> out_reg[$past(word_ch)] == $past(word_data))
      else $error("output not updated at frame end with load low");

   a_held_update: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      s_good_frame and (load_s && !clear_s)
      |=> out_reg[$past(word_ch)] == $past(out_reg[word_ch])
          && in_reg[$past(word_ch)] == $past(word_data))
      else $error("held write changed output or missed input");

   a_load_all: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      load_fall && !clear_s
      |=> out_reg[0] == $past(in_reg[0]) && out_reg[1] == $past(in_reg[1])
          && out_reg[2] == $past(in_reg[2])
          && out_reg[3] == $past(in_reg[3]))
      else $error("load edge did not move all channels");

   a_clear_force: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      clear_s ##1 clear_s
      |-> out_reg[0] == $past(clear_code) && in_reg[3] == $past(clear_code)
          && out_reg[2] == $past(clear_code))
      else $error("clear did not force channel registers");

   a_sdo_stable: assert property (
      @(negedge sclk_i) disable iff (!rst_n_i)
      !frame_sel_n_i ##1 !frame_sel_n_i
      |-> serial_data_out_o == shift_reg[WORD_BITS-1])
      else $error("serial output not the shift register head");

   a_bad_length: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      s_bad_frame and (!clear_s && !load_fall)
      |=> in_reg[0] == $past(in_reg[0]) && in_reg[1] == $past(in_reg[1])
          && out_reg[2] == $past(out_reg[2]))
      else $error("wrong-length frame changed a register");

   a_coding_map: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      bipolar_s && !coding_s ##1 bipolar_s && !coding_s
      |-> core_reg[1] == ($past(out_reg[1]) ^ SIGN_FLIP))
      else $error("twos complement code not converted");

   a_straight_map: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (!bipolar_s || coding_s) ##1 (!bipolar_s || coding_s)
      |-> core_reg[0] == $past(out_reg[0]))
      else $error("straight or offset code was altered");

   a_reset_zero: assert property (
      @(posedge clk_i)
      !rst_n_i |=> (!rst_n_i || (in_reg[0] == RESET_CODE)))
      else $error("reset did not zero channel registers");
endmodule : qdc_update_ctrl

// [tb/qdc_host_model.sv]
// host serial port model driving the converter's serial link
// assumes the bench calls send() only after reset has settled
module qdc_host_model (
   // serial link
   output logic sclk_o,
   output logic frame_sel_n_o,
   output logic sdi_o,
   input wire logic sdo_i
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam real HALF = 62.5;
   initial begin
      sclk_o = 1'b0;
      frame_sel_n_o = 1'b1;
      sdi_o = 1'b0;
   end
   // clock idles low and stands still outside frames, so no edge
   // falls close to a frame edge
   task automatic send(input logic [23:0] w, input int n,
                       output logic [23:0] got);
      got = 24'h000000;
      frame_sel_n_o = 1'b0;
      #(HALF);
      for (int i = 0; i < n; i++) begin
         sdi_o = (i < 24) ? w[23-i] : 1'b0; // msb first
         sclk_o = 1'b1;
         #(HALF);
         sclk_o = 1'b0;
         got = {got[22:0], sdo_i}; // read on falling edge
         #(HALF);
      end
      frame_sel_n_o = 1'b1;
      sdi_o = ~sdi_o;
      #(HALF);
   endtask : send
endmodule : qdc_host_model

// [tb/tb.sv]
// self-checking bench for the quad converter update control
// assumes the host model owns the serial pins
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import qdc_pkg::*;
   logic clk_i, rst_n_i, sclk, fs_n, sdi, serial_data_out;
   logic load_n, clr_n, mid, cod, bip;
   logic [NUM_CH*DATA_BITS-1:0] core;
   logic [DATA_BITS-1:0] in_m [NUM_CH];
   logic [DATA_BITS-1:0] out_m [NUM_CH];
   logic [23:0] got, sent_w, last_w;
   int mismatches, num_checks;
   int seed = 32'h59281663;

   qdc_update_ctrl qdc_update_ctrl_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .sclk_i(sclk), .frame_sel_n_i(fs_n), .serial_data_in_i(sdi),
      .serial_data_out_o(serial_data_out), .load_outputs_n_i(load_n),
      .clear_all_n_i(clr_n), .clear_midscale_i(mid),
      .coding_select_i(cod), .range_bipolar_i(bip), .core_code_o(core));
   qdc_host_model qdc_host_model_inst (.sclk_o(sclk),
      .frame_sel_n_o(fs_n), .sdi_o(sdi), .sdo_i(serial_data_out));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // ***************************************************
   // expectation and compare helpers
   // ***************************************************
   function automatic logic [15:0] conv(input logic [15:0] c);
      return (bip === 1'b1 && cod === 1'b0) ? c ^ SIGN_FLIP : c;
   endfunction : conv

   task automatic chk(input string nm, input logic [23:0] e,
                      input logic [23:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic chk_ch(input int ch);
      chk("core_code", {8'h00, conv(out_m[ch])}, {8'h00, core[ch*16 +: 16]});
   endtask : chk_ch

   task automatic chk_all();
      for (int i = 0; i < NUM_CH; i++) chk_ch(i);
   endtask : chk_all

   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk_i);
   endtask : wait_clk

   // one frame with random code and ignored bits; model follows
   task automatic wr(input logic [1:0] ch, input int n);
      logic [23:0] w;
      w = 24'($random(seed));
      w[17:16] = ch;
      last_w = sent_w;
      sent_w = w;
      qdc_host_model_inst.send(w, n, got);
      wait_clk(6);
      if (n == WORD_BITS && clr_n) begin
         in_m[ch] = w[15:0];
         if (!load_n) out_m[ch] = w[15:0];
      end
   endtask : wr

   task automatic set_load(input logic v);
      @(negedge clk_i);
      load_n = v;
      wait_clk(6);
      if (!v) for (int i = 0; i < NUM_CH; i++) out_m[i] = in_m[i];
   endtask : set_load

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim

   // ***************************************************
   // main sequence
   // ***************************************************
   initial begin
      rst_n_i = 1'b0;
      load_n = 1'b0; // driven from time zero
      clr_n = 1'b1;
      mid = 1'b0;
      cod = 1'b1;
      bip = 1'b0;
      sent_w = SHIFT_RESET;
      for (int i = 0; i < NUM_CH; i++) in_m[i] = RESET_CODE;
      for (int i = 0; i < NUM_CH; i++) out_m[i] = RESET_CODE;
      wait_clk(3);
      rst_n_i = 1'b1;
      wait_clk(3);
      chk_all();
      $display("test reset done");
      for (int k = 0; k < NUM_CH; k++) begin
         wr(k[1:0], WORD_BITS);
         chk("serial_out", last_w, got);
         chk_all();
      end
      $display("test immediate update done");
      set_load(1'b1);
      for (int k = 0; k < NUM_CH; k++) begin
         wr(k[1:0], WORD_BITS);
         chk_all();
      end
      set_load(1'b0);
      chk_all();
      wr(2'h2, 23);
      chk_all();
      wr(2'h3, 25);
      chk_all();
      $display("test held load done");
      for (int m = 0; m < 2; m++) begin
         set_load(1'b1);
         wr(2'h1, WORD_BITS);
         mid = m[0];
         clr_n = 1'b0;
         wait_clk(2);
         load_n = 1'b0;
         wait_clk(6);
         for (int i = 0; i < NUM_CH; i++) begin
            in_m[i] = m[0] ? MID_SCALE : ZERO_SCALE;
            out_m[i] = in_m[i];
         end
         chk_all();
         wr(2'h0, WORD_BITS);
         chk_all();
         clr_n = 1'b1;
         wait_clk(6);
         chk_all();
      end
      $display("test clear done");
      for (int m = 0; m < 3; m++) begin
         bip = (m > 0);
         cod = (m == 2);
         wait_clk(6);
         wr(m[1:0], WORD_BITS);
         chk_ch(m);
      end
      $display("test coding done");
      // clear in twos complement must still reach zero or midscale
      cod = 1'b0;
      for (int m = 0; m < 2; m++) begin
         mid = m[0];
         clr_n = 1'b0;
         wait_clk(6);
         for (int i = 0; i < NUM_CH; i++) begin
            in_m[i] = conv(m[0] ? MID_SCALE : ZERO_SCALE);
            out_m[i] = in_m[i];
         end
         chk_all();
         clr_n = 1'b1;
         wait_clk(6);
      end
      $display("test bipolar clear done");
      rst_n_i = 1'b0;
      wait_clk(3);
      rst_n_i = 1'b1;
      wait_clk(6);
      sent_w = SHIFT_RESET;
      for (int i = 0; i < NUM_CH; i++) in_m[i] = RESET_CODE;
      for (int i = 0; i < NUM_CH; i++) out_m[i] = RESET_CODE;
      chk_all();
      wr(2'h1, WORD_BITS);
      chk("serial_out", last_w, got);
      chk_all();
      $display("test second reset done");
      end_sim();
   end

   initial begin
      #500us;
      mismatches++;
      end_sim();
   end
endmodule : tb
